// ### hw/eepc_regs.svh
`ifndef EEPC_REGS_SVH
`define EEPC_REGS_SVH
// ****************************************************************
// Register indices; each byte address is four times its index
// ****************************************************************
`define EEPC_IDX_PROG 10'h0F2
`define EEPC_IDX_CFG 10'h0F1
`define EEPC_IDX_TEST 10'h0F3
`define EEPC_IDX_STAT 10'h0F4
`define EEPC_IDX_ALAT 10'h0F8
`define EEPC_IDX_DLAT 10'h0FC
`define EEPC_OFS_PROG {`EEPC_IDX_PROG, 2'b00}
`define EEPC_OFS_CFG {`EEPC_IDX_CFG, 2'b00}
`define EEPC_OFS_TEST {`EEPC_IDX_TEST, 2'b00}
`define EEPC_OFS_STAT {`EEPC_IDX_STAT, 2'b00}
`define EEPC_OFS_ALAT {`EEPC_IDX_ALAT, 2'b00}
`define EEPC_OFS_DLAT {`EEPC_IDX_DLAT, 2'b00}
`define EEPC_ARR_LO 12'hD00
`define EEPC_ARR_HI 12'hFFF
// ****************************************************************
// Field positions of the program control register
// ****************************************************************
`define EEPC_B_PGM 0
`define EEPC_B_LAT 1
`define EEPC_B_ERASE 2
`define EEPC_B_ROW 3
`define EEPC_B_BYTE 4
`define EEPC_B_BULK_ERASE_PROTECT 7
// Config register: protection lock
`define EEPC_B_LOCK 1
// Test register: charge pump monitor
`define EEPC_B_CPM 1
// ****************************************************************
// Reset values
// ****************************************************************
`define EEPC_RST_PROG 8'h80
`define EEPC_RST_CFG 8'h00
`define EEPC_RST_TEST 8'h00
`endif

// ### hw/eepc_pkg.sv
package eepc_pkg;
  typedef enum logic [1:0] {
    EEPC_OP_PROGRAM,
    EEPC_OP_BULK,
    EEPC_OP_ROW,
    EEPC_OP_BYTE
  } eepc_op_t;
  typedef enum logic {
    EEPC_ST_IDLE,
    EEPC_ST_DATA
  } eepc_st_t;
endpackage

// ### hw/eepc_top.sv
`timescale 1ns/10ps
`include "eepc_regs.svh"
// Contract
// - Protection bit blocks bulk and row erase
// - Protection writable only when idle and unlocked
// - Byte and row bits pick erase size
// - Size bits ignored when not erasing
// - Byte erase hits only latched location
// - Erase bit selects erase or program setup
// - Latch bit makes next array write latch
// - Control bits frozen while enable set
// - Enable sets only after latch set
// - Enable bit drives program voltage
// - Array writes ignored while enable set
// - Control bits writable together or apart
// - Monitor bit routes pump to pin
// - Lock bit freezes protection, written once in normal mode, any number of times in special mode
module eepc_top
  import eepc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic special_mode_n,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic pgm_voltage_on,
  output logic erase_mode,
  output logic [1:0] op_kind,
  output logic [11:0] prog_addr,
  output logic [15:0] prog_data,
  output logic prog_word,
  output logic array_read_en,
  output logic pump_to_pin
);
  // ****************************************************************
  // Address phase capture
  // ****************************************************************
  logic sel_reg, wr_reg;
  logic [11:0] addr_reg;
  logic [2:0] size_reg;
  logic [7:0] prog_reg, prog_next, cfg_reg, cfg_next, test_reg, test_next;
  logic lock_set_reg;
  logic smn_s1, smn_s2, smn_s3, smn_reg;
  eepc_st_t lat_st;
  logic [11:0] alat_reg;
  logic [15:0] dlat_reg;
  logic word_reg;

  wire active = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 12'h000;
      size_reg <= 3'h0;
    end else if (hready) begin
      sel_reg <= active;
      wr_reg <= hwrite;
      addr_reg <= haddr[11:0];
      size_reg <= hsize;
    end
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction

  wire wr_ph = sel_reg & wr_reg;
  wire wr_prog = wr_ph & hit(addr_reg, `EEPC_OFS_PROG);
  wire wr_cfg = wr_ph & hit(addr_reg, `EEPC_OFS_CFG);
  wire wr_test = wr_ph & hit(addr_reg, `EEPC_OFS_TEST);
  wire wr_arr = wr_ph & (addr_reg >= `EEPC_ARR_LO);
  wire pgm = prog_reg[`EEPC_B_PGM];
  wire lat = prog_reg[`EEPC_B_LAT];
  wire lock = cfg_reg[`EEPC_B_LOCK];
  wire [7:0] wd = hwdata[7:0];

  // ****************************************************************
  // Write data lanes of the array
  // ****************************************************************
  wire word_wr = (size_reg == 3'h1) & ~addr_reg[0];
  wire [15:0] half_lane = addr_reg[1] ? hwdata[31:16] : hwdata[15:0];
  wire [7:0] byte_lane = addr_reg[0] ? half_lane[15:8] : half_lane[7:0];

  // ****************************************************************
  // Mode strap sampling
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smn_s1 <= 1'b1;
      smn_s2 <= 1'b1;
      smn_s3 <= 1'b1;
      smn_reg <= 1'b1;
    end else begin
      smn_s1 <= special_mode_n;
      smn_s2 <= smn_s1;
      smn_s3 <= smn_s2;
      if (smn_s2 == smn_s3)
        smn_reg <= smn_s3;
    end
  end

  // ****************************************************************
  // Program control register
  // ****************************************************************
  wire cfg_ok = ~pgm;
  wire bulk_erase_protect_ok = ~pgm & ~lock;
  wire pgm_set_ok = lat;
  always_comb begin
    prog_next = prog_reg;
    if (wr_prog) begin
      if (bulk_erase_protect_ok)
        prog_next[`EEPC_B_BULK_ERASE_PROTECT] = wd[`EEPC_B_BULK_ERASE_PROTECT];
      if (cfg_ok) begin
        prog_next[`EEPC_B_BYTE] = wd[`EEPC_B_BYTE];
        prog_next[`EEPC_B_ROW] = wd[`EEPC_B_ROW];
        prog_next[`EEPC_B_ERASE] = wd[`EEPC_B_ERASE];
        prog_next[`EEPC_B_LAT] = wd[`EEPC_B_LAT];
      end
      prog_next[`EEPC_B_PGM] = wd[`EEPC_B_PGM] & pgm_set_ok;
    end
    prog_next[6:5] = 2'b00;
  end

  // ****************************************************************
  // Config and test registers
  // ****************************************************************
  wire lock_wr_ok = ~smn_reg | ~lock_set_reg;
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg && lock_wr_ok)
      cfg_next[`EEPC_B_LOCK] = wd[`EEPC_B_LOCK];
    test_next = test_reg;
    if (wr_test && !smn_reg)
      test_next[`EEPC_B_CPM] = wd[`EEPC_B_CPM];
    if (smn_reg)
      test_next = 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_reg <= `EEPC_RST_PROG;
      cfg_reg <= `EEPC_RST_CFG;
      test_reg <= `EEPC_RST_TEST;
      lock_set_reg <= 1'b0;
    end else begin
      prog_reg <= prog_next;
      cfg_reg <= cfg_next;
      test_reg <= test_next;
      if (wr_cfg)
        lock_set_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Programming latches
  // ****************************************************************
  wire take_lat = wr_arr & lat & ~pgm;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_st <= EEPC_ST_IDLE;
      alat_reg <= 12'h000;
      dlat_reg <= 16'h0000;
      word_reg <= 1'b0;
    end else if (take_lat) begin
      lat_st <= EEPC_ST_DATA;
      alat_reg <= addr_reg;
      word_reg <= word_wr;
      dlat_reg <= word_wr ? half_lane : {8'h00, byte_lane};
    end else if (!lat) begin
      lat_st <= EEPC_ST_IDLE;
    end
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  eepc_op_t op;
  wire er = prog_reg[`EEPC_B_ERASE];
  wire bsel = prog_reg[`EEPC_B_BYTE];
  wire rsel = prog_reg[`EEPC_B_ROW];
  wire bulk_erase_protect = prog_reg[`EEPC_B_BULK_ERASE_PROTECT];
  always_comb begin
    case ({er, bsel, rsel})
      3'b100: op = EEPC_OP_BULK;
      3'b101: op = EEPC_OP_ROW;
      3'b110, 3'b111: op = EEPC_OP_BYTE;
      default: op = EEPC_OP_PROGRAM;
    endcase
  end
  // Bulk and row erase refused under protection
  wire refused = bulk_erase_protect & (op == EEPC_OP_BULK || op == EEPC_OP_ROW);
  wire volt_next = pgm & ~refused & (lat_st == EEPC_ST_DATA);

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************
  wire rd_stat = hit(haddr[11:0], `EEPC_OFS_STAT);
  wire [7:0] stat = {5'h00, refused, lat_st == EEPC_ST_DATA, volt_next};
  wire [31:0] rd_mux =
    hit(haddr[11:0], `EEPC_OFS_PROG) ? {24'h0, prog_reg} :
    hit(haddr[11:0], `EEPC_OFS_CFG) ? {24'h0, cfg_reg} :
    hit(haddr[11:0], `EEPC_OFS_TEST) ? {24'h0, test_reg} :
    rd_stat ? {24'h0, stat} :
    hit(haddr[11:0], `EEPC_OFS_ALAT) ? {20'h0, alat_reg} :
    hit(haddr[11:0], `EEPC_OFS_DLAT) ? {16'h0, dlat_reg} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pgm_voltage_on <= 1'b0;
      erase_mode <= 1'b0;
      op_kind <= 2'h0;
      prog_addr <= 12'h000;
      prog_data <= 16'h0000;
      prog_word <= 1'b0;
      array_read_en <= 1'b1;
      pump_to_pin <= 1'b0;
    end else begin
      if (active && !hwrite)
        hrdata <= rd_mux;
      pgm_voltage_on <= volt_next;
      erase_mode <= er;
      op_kind <= op;
      prog_addr <= alat_reg;
      prog_data <= dlat_reg;
      prog_word <= word_reg;
      array_read_en <= ~lat;
      pump_to_pin <= test_reg[`EEPC_B_CPM];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_pgm_needs_lat: assert property (
    @(posedge hclk) disable iff (!hresetn) $rose(pgm) |-> $past(lat))
    else $error("enable set without latch");
  a_frozen_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(pgm) |-> $stable(prog_reg[4:1])) else $error("bits changed");
  a_bulk_erase_protect_lock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($past(lock) || $past(pgm)) |-> $stable(bulk_erase_protect))
    else $error("protect bit changed");
  a_no_refused_v: assert property (
    @(posedge hclk) disable iff (!hresetn) refused |=> !pgm_voltage_on)
    else $error("protected erase ran");
  a_volt_follows: assert property (
    @(posedge hclk) disable iff (!hresetn) !pgm |=> !pgm_voltage_on)
    else $error("voltage without enable");
  a_latch_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(pgm) |-> $stable(alat_reg) && $stable(dlat_reg))
    else $error("latch changed");
  a_pump_pin: assert property (
    @(posedge hclk) disable iff (!hresetn)
    test_reg[`EEPC_B_CPM] |=> pump_to_pin) else $error("pump pin");
  a_read_mode: assert property (
    @(posedge hclk) disable iff (!hresetn) !lat |=> array_read_en)
    else $error("reads blocked");
  a_prog_kind: assert property (
    @(posedge hclk) disable iff (!hresetn) !er |=> op_kind == 2'h0)
    else $error("size bits leaked");
  a_lock_once: assert property (
    @(posedge hclk) disable iff (!hresetn)
    smn_reg && $past(lock_set_reg) && $past(smn_reg) |-> $stable(lock))
    else $error("lock rewritten");
  a_bulk_kind: assert property (
    @(posedge hclk) disable iff (!hresetn)
    er && !bsel && !rsel |=> op_kind == 2'h1) else $error("not bulk");
  a_row_kind: assert property (
    @(posedge hclk) disable iff (!hresetn)
    er && !bsel && rsel |=> op_kind == 2'h2) else $error("not row");
  a_byte_kind: assert property (
    @(posedge hclk) disable iff (!hresetn)
    er && bsel |=> op_kind == 2'h3) else $error("not byte erase");
  a_erase_out: assert property (
    @(posedge hclk) disable iff (!hresetn) er |=> erase_mode)
    else $error("erase mode not shown");
  a_volt_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pgm && !refused && lat_st == EEPC_ST_DATA |=> pgm_voltage_on)
    else $error("voltage not applied");
  a_lat_take: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take_lat |=> alat_reg == $past(addr_reg)) else $error("not latched");
  a_loc_out: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take_lat |=> ##1 prog_addr == $past(alat_reg))
    else $error("wrong location");
  a_pgm_blocked: assert property (
    @(posedge hclk) disable iff (!hresetn) wr_prog && !lat |=> !pgm)
    else $error("enable set while latch clear");
  a_cpm_normal: assert property (
    @(posedge hclk) disable iff (!hresetn)
    smn_reg |=> !test_reg[`EEPC_B_CPM]) else $error("test bit in normal");
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
`include "eepc_regs.svh"
module tb
  import eepc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, special_mode_n;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans, op_kind;
  logic [2:0] hsize;
  logic hreadyout, hresp, pgm_voltage_on, erase_mode, prog_word;
  logic array_read_en, pump_to_pin;
  logic [11:0] prog_addr, a, a0;
  logic [15:0] prog_data, d0;
  logic [7:0] kv [4];
  int err_total, num_checks;
  eepc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .special_mode_n(special_mode_n), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pgm_voltage_on(pgm_voltage_on),
    .erase_mode(erase_mode), .op_kind(op_kind), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_word(prog_word),
    .array_read_en(array_read_en), .pump_to_pin(pump_to_pin));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic v_exp(input logic b, input int k);
    return !(b && (k == 1 || k == 2));
  endfunction
  function automatic logic [15:0] lane(input logic [11:0] ad,
                                       input logic [31:0] d,
                                       input logic [2:0] sz);
    logic [15:0] h;
    h = ad[1] ? d[31:16] : d[15:0];
    if (sz == 3'b001)
      return h;
    return {8'h00, ad[0] ? h[15:8] : h[7:0]};
  endfunction
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] ad,
                     input logic [2:0] sz, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, ad};
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    bus(1'b1, ad, 3'b010, {24'h000000, d});
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 3'b010, 32'h00000000);
    chk("reg", {24'h000000, e}, {24'h000000, rd[7:0]});
    chk("resp", 32'h00000000, {31'h00000000, hresp});
  endtask
  task automatic arr(input logic [2:0] sz);
    seed = xs(seed);
    a = 12'hD00 + 12'(seed % 32'd768);
    if (sz == 3'b001)
      a = a & 12'hFFE;
    bus(1'b1, a, sz, seed);
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask
  // ****************************************************************
  // Clock, reset, watchdog
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    summarize();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; special_mode_n = 1'b1;
    err_total = 0; num_checks = 0; seed = 32'h93B98CF4;
    kv = '{8'h1A, 8'h06, 8'h0E, 8'h16};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("volt", 1'b0, pgm_voltage_on);
    chk("rden", 1'b1, array_read_en);
    rdc(`EEPC_OFS_PROG, 8'h80);
    rdc({10'h0F0, 2'b00}, 8'h00);
    wr(`EEPC_OFS_PROG, 8'h13);
    rdc(`EEPC_OFS_PROG, 8'h12);
    settle();
    chk("rden", 1'b0, array_read_en);
    arr(3'b001);
    settle();
    chk("addr", a, prog_addr);
    chk("data", lane(a, seed, 3'b001), prog_data);
    chk("word", 1'b1, prog_word);
    wr(`EEPC_OFS_PROG, 8'h17);
    wr(`EEPC_OFS_PROG, 8'h8B);
    rdc(`EEPC_OFS_PROG, 8'h17);
    a0 = a;
    d0 = lane(a, seed, 3'b001);
    arr(3'b001);
    settle();
    chk("hold", a0, prog_addr);
    chk("hdat", d0, prog_data);
    chk("volt", 1'b1, pgm_voltage_on);
    wr(`EEPC_OFS_PROG, 8'h16);
    arr(3'b000);
    settle();
    chk("volt", 1'b0, pgm_voltage_on);
    chk("addr", a, prog_addr);
    chk("data", lane(a, seed, 3'b000), prog_data);
    chk("word", 1'b0, prog_word);
    wr(`EEPC_OFS_PROG, 8'h00);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`EEPC_OFS_PROG, {b[0], kv[k][6:0]});
        arr(3'b001);
        wr(`EEPC_OFS_PROG, {b[0], kv[k][6:0]} | 8'h01);
        settle();
        chk("kind", 32'(k), 32'(op_kind));
        chk("erase", k != 0, erase_mode);
        chk("volt", v_exp(b[0], k), pgm_voltage_on);
        rdc(`EEPC_OFS_STAT,
            {5'h00, !v_exp(b[0], k), 1'b1, v_exp(b[0], k)});
        wr(`EEPC_OFS_PROG, {b[0], kv[k][6:0]});
        wr(`EEPC_OFS_PROG, {b[0], 7'h00});
        settle();
        chk("rden", 1'b1, array_read_en);
      end
    end
    wr(`EEPC_OFS_TEST, 8'h02);
    settle();
    chk("pump", 1'b0, pump_to_pin);
    rdc(`EEPC_OFS_TEST, 8'h00);
    special_mode_n <= 1'b0;
    repeat (5) @(posedge hclk);
    wr(`EEPC_OFS_TEST, 8'h02);
    settle();
    chk("pump", 1'b1, pump_to_pin);
    special_mode_n <= 1'b1;
    repeat (5) @(posedge hclk);
    wr(`EEPC_OFS_CFG, 8'h02);
    wr(`EEPC_OFS_PROG, 8'h00);
    rdc(`EEPC_OFS_PROG, 8'h80);
    chk("pump", 1'b0, pump_to_pin);
    wr(`EEPC_OFS_CFG, 8'h00);
    rdc(`EEPC_OFS_CFG, 8'h02);
    summarize();
  end
endmodule
